//--- design/hces_top.sv
// Purpose: Host command checker with error cause register
// Assumes: Motion state inputs come from logic on core_clk
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "hces_params.svh"
module hces_top (
  // Clock and reset
  input logic core_clk,
  input logic rst_b,
  // AHB-Lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Motion side state
  input hces_pkg::hces_motion_t motion,
  input logic [3:0] capt_taken,
  // Accepted commands toward the axes
  output hces_pkg::hces_issue_t issue,
  output logic [7:0] work_modes,
  // Interrupt
  output logic irq
);
  import hces_pkg::*;

  logic rst_meta;
  logic rst_sync_b;
  logic bus_take;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] param_reg;
  logic [3:0] reg_sel;
  logic [1:0] irq_mask;
  logic [1:0] irq_sts;
  logic [1:0] irq_set;
  hces_state_t state;
  hces_state_t next_state;
  hces_cmd_t cur_cmd;
  logic [15:0] judge_err;
  logic [15:0] verdict_err;
  logic [15:0] err_sts;
  logic [15:0] err_set;
  logic ret_code;
  logic [3:0] armed;
  logic [3:0] arm_set;
  logic [3:0] gear;
  logic [1:0] work_mode [4];
  logic [31:0] param_tab [4][4];
  logic cmd_wr;
  logic commit;
  logic accept;
  logic busy_view;
  logic [31:0] next_rdata;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // Address phase match for a read
  function automatic logic rd_hit(input logic [7:0] off);
    return bus_take && !hwrite && (haddr[`HCES_DEC] == off);
  endfunction

  // Data phase match for a write
  function automatic logic wr_hit(input logic [7:0] off);
    return wr_pend && (wr_addr == off);
  endfunction

  // Never stalls, so the slave is always ready
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Only whole words are taken; other sizes are ignored
  assign bus_take = hsel && htrans[1] && hready && (hsize == `HCES_HSIZE_WORD);

  // Write address held for the data phase
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= bus_take && hwrite;
      wr_addr <= haddr[`HCES_DEC];
    end
  end

  // Parameter staging register
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      param_reg <= `HCES_WORD_RESET;
    end else if (wr_hit(`HCES_ADDR_PARAM)) begin
      param_reg <= hwdata;
    end
  end

  // Readback selector and interrupt mask
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_sel <= 4'h0;
      irq_mask <= 2'h0;
    end else begin
      if (wr_hit(`HCES_ADDR_SEL)) begin
        reg_sel <= hwdata[3:0];
      end
      if (wr_hit(`HCES_ADDR_IRQ_MASK)) begin
        irq_mask <= hwdata[1:0];
      end
    end
  end

  // A command written while one is in flight is dropped
  assign cmd_wr = wr_pend && (wr_addr == `HCES_ADDR_CMD) && (state == ST_IDLE);
  assign commit = state == ST_COMMIT;
  assign accept = commit && (verdict_err == `HCES_ERR_RESET);

  // Command sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_wr) begin
          next_state = ST_JUDGE;
        end
      end
      ST_JUDGE: begin
        next_state = ST_COMMIT;
      end
      ST_COMMIT: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Command latched with the staged parameter
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cur_cmd <= '0;
    end else if (cmd_wr) begin
      cur_cmd.op <= hwdata[`HCES_CMD_OP];
      cur_cmd.axis <= hwdata[`HCES_CMD_AXIS];
      cur_cmd.value <= param_reg;
    end
  end

  // Gear mode flags per axis
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gear[i] = work_mode[i] == `HCES_MODE_GEAR;
    end
  end

  hces_judge u_judge (
    .cmd(cur_cmd),
    .motion(motion),
    .armed(armed),
    .gear(gear),
    .err(judge_err)
  );

  // Verdict held one cycle so the check and the commit are split
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      verdict_err <= `HCES_ERR_RESET;
    end else if (state == ST_JUDGE) begin
      verdict_err <= judge_err & `HCES_ERR_USED;
    end
  end

  // Return code of the last command
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ret_code <= `HCES_RET_OK;
    end else if (commit) begin
      ret_code <= accept ? `HCES_RET_OK : `HCES_RET_REJECT;
    end
  end

  // Sticky causes; a new cause beats the clearing read
  assign err_set = commit ? verdict_err : `HCES_ERR_RESET;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      err_sts <= `HCES_ERR_RESET;
    end else if (rd_hit(`HCES_ADDR_ERR)) begin
      err_sts <= err_set;
    end else begin
      err_sts <= err_sts | err_set;
    end
  end

  // Stored parameters move only on acceptance
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int a = 0; a < 4; a++) begin
        for (int k = 0; k < 4; k++) begin
          param_tab[a][k] <= `HCES_WORD_RESET;
        end
      end
    end else if (accept) begin
      case (cur_cmd.op)
        `HCES_OP_TGT_POS: begin
          param_tab[cur_cmd.axis][`HCES_KIND_POS] <= cur_cmd.value;
        end
        `HCES_OP_VEL: begin
          param_tab[cur_cmd.axis][`HCES_KIND_VEL] <= cur_cmd.value;
        end
        `HCES_OP_ACC: begin
          param_tab[cur_cmd.axis][`HCES_KIND_ACC] <= cur_cmd.value;
        end
        `HCES_OP_JERK: begin
          param_tab[cur_cmd.axis][`HCES_KIND_JERK] <= cur_cmd.value;
        end
        default: begin
        end
      endcase
    end
  end

  // Work mode per axis
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int a = 0; a < 4; a++) begin
        work_mode[a] <= `HCES_MODE_RESET;
      end
    end else if (accept && (cur_cmd.op == `HCES_OP_MODE)) begin
      work_mode[cur_cmd.axis] <= cur_cmd.value[`HCES_MODE_FIELD];
    end
  end

  always_comb begin
    for (int a = 0; a < 4; a++) begin
      work_modes[a*2 +: 2] = work_mode[a];
    end
  end

  // Capture armed until the axis reports the capture
  always_comb begin
    arm_set = 4'h0;
    if (accept && ((cur_cmd.op == `HCES_OP_IDX_CAPT) ||
        (cur_cmd.op == `HCES_OP_HOME_CAPT))) begin
      arm_set[cur_cmd.axis] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      armed <= 4'h0;
    end else begin
      armed <= (armed & ~capt_taken) | arm_set;
    end
  end

  // Accepted command handed to the axes for one cycle
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      issue <= '0;
    end else begin
      issue.valid <= accept;
      issue.cmd <= cur_cmd;
    end
  end

  // Interrupt events: rejection and acceptance
  always_comb begin
    irq_set = 2'h0;
    irq_set[`HCES_IRQ_REJECT] = commit && !accept;
    irq_set[`HCES_IRQ_ACCEPT] = accept;
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_sts <= 2'h0;
    end else if (rd_hit(`HCES_ADDR_IRQ_STS)) begin
      irq_sts <= irq_set;
    end else begin
      irq_sts <= irq_sts | irq_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts & irq_mask);
    end
  end

  // Busy also covers a command write in this very cycle
  assign busy_view = (state != ST_IDLE) || (wr_pend && (wr_addr == `HCES_ADDR_CMD));

  // Read mux, sampled in the address phase
  always_comb begin
    next_rdata = `HCES_WORD_RESET;
    case (haddr[`HCES_DEC])
      `HCES_ADDR_PARAM: begin
        next_rdata = param_reg;
      end
      `HCES_ADDR_RET: begin
        next_rdata = {30'h00000000, busy_view, ret_code};
      end
      `HCES_ADDR_ERR: begin
        next_rdata = {16'h0000, err_sts & `HCES_ERR_USED};
      end
      `HCES_ADDR_IRQ_STS: begin
        next_rdata = {30'h00000000, irq_sts};
      end
      `HCES_ADDR_IRQ_MASK: begin
        next_rdata = {30'h00000000, irq_mask};
      end
      `HCES_ADDR_SEL: begin
        next_rdata = {28'h0000000, reg_sel};
      end
      `HCES_ADDR_RDBK: begin
        next_rdata = param_tab[reg_sel[`HCES_SEL_AXIS]][reg_sel[`HCES_SEL_KIND]];
      end
      `HCES_ADDR_STATE: begin
        next_rdata = {18'h00000, work_modes, armed, state};
      end
      default: begin
        next_rdata = `HCES_WORD_RESET;
      end
    endcase
  end

  // Read data from a flop, stands for the data phase
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hrdata <= `HCES_WORD_RESET;
    end else if (bus_take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end
endmodule

//--- design/hces_params.svh
// Purpose: Named constants of the command checker
// Assumes: Included by the package and by every design module
// Notes: Offsets are AHB byte addresses, low eight address bits
`ifndef HCES_PARAMS_SVH
`define HCES_PARAMS_SVH
// Register byte offsets
`define HCES_ADDR_PARAM 8'h00
`define HCES_ADDR_CMD 8'h04
`define HCES_ADDR_RET 8'h08
`define HCES_ADDR_ERR 8'h0c
`define HCES_ADDR_IRQ_STS 8'h10
`define HCES_ADDR_IRQ_MASK 8'h14
`define HCES_ADDR_SEL 8'h18
`define HCES_ADDR_RDBK 8'h1c
`define HCES_ADDR_STATE 8'h20
`define HCES_DEC 7:0
`define HCES_HSIZE_WORD 3'h2
// Command word fields
`define HCES_CMD_OP 7:0
`define HCES_CMD_AXIS 9:8
`define HCES_SEL_AXIS 1:0
`define HCES_SEL_KIND 3:2
`define HCES_UPD_MASK 3:0
`define HCES_MODE_FIELD 1:0
// Command opcodes
`define HCES_OP_TGT_POS 8'h01
`define HCES_OP_VEL 8'h02
`define HCES_OP_ACC 8'h03
`define HCES_OP_ACT_POS 8'h04
`define HCES_OP_JERK 8'h05
`define HCES_OP_GAIN 8'h06
`define HCES_OP_LIMIT 8'h07
`define HCES_OP_MULTI_UPD 8'h08
`define HCES_OP_DRV_CLR 8'h09
`define HCES_OP_INTR 8'h0a
`define HCES_OP_MODE 8'h0b
`define HCES_OP_IDX_CAPT 8'h0c
`define HCES_OP_HOME_CAPT 8'h0d
// Error flag positions, bit 5 reserved
`define HCES_ERR_OVF 0
`define HCES_ERR_ILL 1
`define HCES_ERR_MASK 2
`define HCES_ERR_DRV 3
`define HCES_ERR_INT 4
`define HCES_ERR_MODE 6
`define HCES_ERR_CAPT 7
`define HCES_ERR_USED 16'h00df
`define HCES_ERR_RESET 16'h0000
// Value limits by magnitude
`define HCES_POS_MAX 32'h3fffffff
`define HCES_VEL_MAX 32'h00ffffff
`define HCES_ACC_MAX 32'h00ffffff
// Parameter kinds, work mode, interrupt bits, resets
`define HCES_KIND_POS 2'h0
`define HCES_KIND_VEL 2'h1
`define HCES_KIND_ACC 2'h2
`define HCES_KIND_JERK 2'h3
`define HCES_MODE_GEAR 2'h3
`define HCES_MODE_RESET 2'h0
`define HCES_IRQ_REJECT 0
`define HCES_IRQ_ACCEPT 1
`define HCES_WORD_RESET 32'h00000000
`define HCES_RET_REJECT 1'b1
`define HCES_RET_OK 1'b0
`endif

//--- design/hces_pkg.sv
// Purpose: Types shared by the command checker modules
// Assumes: Constants come from the params header
// Notes: Opcode values live in the header
package hces_pkg;
  `include "hces_params.svh"

  typedef enum logic [7:0] {
    OP_NONE = 8'h00,
    OP_TGT_POS = `HCES_OP_TGT_POS,
    OP_VEL = `HCES_OP_VEL,
    OP_ACC = `HCES_OP_ACC,
    OP_ACT_POS = `HCES_OP_ACT_POS,
    OP_JERK = `HCES_OP_JERK,
    OP_GAIN = `HCES_OP_GAIN,
    OP_LIMIT = `HCES_OP_LIMIT,
    OP_MULTI_UPD = `HCES_OP_MULTI_UPD,
    OP_DRV_CLR = `HCES_OP_DRV_CLR,
    OP_INTR = `HCES_OP_INTR,
    OP_MODE = `HCES_OP_MODE,
    OP_IDX_CAPT = `HCES_OP_IDX_CAPT,
    OP_HOME_CAPT = `HCES_OP_HOME_CAPT
  } hces_op_t;

  typedef struct packed {
    logic [7:0] op;
    logic [1:0] axis;
    logic [31:0] value;
  } hces_cmd_t;

  typedef struct packed {
    logic [3:0] moving;
    logic [3:0] servo_on;
    logic [3:0] capt_done;
    logic evt_pending;
  } hces_motion_t;

  typedef struct packed {
    logic valid;
    hces_cmd_t cmd;
  } hces_issue_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_JUDGE = 2'b01,
    ST_COMMIT = 2'b11
  } hces_state_t;
endpackage

//--- design/hces_judge.sv
// Purpose: Classifies one command into error causes
// Assumes: Motion state and axis flags are on the core clock
// Notes: Purely combinational; an empty result means legal
`timescale 1ns/1ps
`include "hces_params.svh"
module hces_judge (
  // Command under test
  input hces_pkg::hces_cmd_t cmd,
  // Axis state
  input hces_pkg::hces_motion_t motion,
  input logic [3:0] armed,
  input logic [3:0] gear,
  // Verdict
  output logic [15:0] err
);
  import hces_pkg::*;

  // Two's complement magnitude against a limit
  function automatic logic over(input logic [31:0] v, input logic [31:0] lim);
    logic [31:0] mag;
    mag = v[31] ? (~v + 32'h00000001) : v;
    return mag > lim;
  endfunction

  always_comb begin
    logic [1:0] ax;
    ax = cmd.axis;
    err = `HCES_ERR_RESET;
    case (cmd.op)
      `HCES_OP_TGT_POS, `HCES_OP_ACT_POS: begin
        err[`HCES_ERR_OVF] = over(cmd.value, `HCES_POS_MAX);
      end
      `HCES_OP_VEL: begin
        err[`HCES_ERR_OVF] = over(cmd.value, `HCES_VEL_MAX);
        err[`HCES_ERR_ILL] = cmd.value[31];
      end
      `HCES_OP_ACC: begin
        err[`HCES_ERR_OVF] = over(cmd.value, `HCES_ACC_MAX);
        err[`HCES_ERR_ILL] = cmd.value[31];
      end
      `HCES_OP_JERK, `HCES_OP_GAIN, `HCES_OP_LIMIT: begin
        err[`HCES_ERR_ILL] = cmd.value[31];
      end
      `HCES_OP_MULTI_UPD: begin
        err[`HCES_ERR_MASK] = cmd.value[`HCES_UPD_MASK] == 4'h0;
      end
      `HCES_OP_DRV_CLR: begin
        err[`HCES_ERR_DRV] = motion.servo_on[ax];
      end
      `HCES_OP_INTR: begin
        err[`HCES_ERR_INT] = !motion.evt_pending;
      end
      `HCES_OP_MODE: begin
        // Gear mode axes may switch while moving
        err[`HCES_ERR_MODE] = motion.moving[ax] && !gear[ax];
      end
      `HCES_OP_IDX_CAPT, `HCES_OP_HOME_CAPT: begin
        err[`HCES_ERR_CAPT] = motion.capt_done[ax] || armed[ax];
      end
      default: begin
        err = `HCES_ERR_RESET;
      end
    endcase
  end
endmodule

//--- testbench/hces_top_sva.sv
// Purpose: Port checks of the command checker
// Assumes: One command in flight at a time
// Notes: Verdicts show three edges after the command data phase
`timescale 1ns/1ps
`include "hces_params.svh"
module hces_top_sva (
  // Clock and reset
  input logic core_clk,
  input logic rst_b,
  // Bus
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  // Axis side
  input hces_pkg::hces_motion_t motion,
  input logic [3:0] capt_taken,
  input hces_pkg::hces_issue_t issue,
  input logic [7:0] work_modes,
  input logic irq
);
  import hces_pkg::*;
  logic wr_q;
  logic rd_q;
  logic [7:0] adr_q;
  logic [31:0] prm;
  logic [31:0] cmd_q;
  logic go;
  logic [7:0] op;
  logic [1:0] ax;
  logic take;
  assign take = hsel && htrans[1] && hready && hsize == `HCES_HSIZE_WORD;
  assign go = wr_q && adr_q == `HCES_ADDR_CMD;
  assign op = hwdata[7:0];
  assign ax = hwdata[9:8];
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      adr_q <= haddr[7:0];
    end
  end
  // Shadow of staged value and launched command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prm <= 32'h0;
      cmd_q <= 32'h0;
    end else begin
      if (wr_q && adr_q == `HCES_ADDR_PARAM) prm <= hwdata;
      if (go) cmd_q <= hwdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_drop(c);
    go && c |-> ##1 !issue.valid [*3];
  endproperty
  sequence s_issued;
    issue.valid && issue.cmd.op == cmd_q[7:0] && issue.cmd.value == prm;
  endsequence
  a_ovf_drop: assert property (p_drop((op == OP_TGT_POS || op == OP_ACT_POS) &&
    prm[31:30] == 2'b01)) else $error("overflow command issued");
  a_neg_drop: assert property (p_drop(op inside {OP_VEL, OP_ACC, OP_JERK, OP_GAIN,
    OP_LIMIT} && prm[31])) else $error("negative parameter issued");
  a_mask_drop: assert property (p_drop(op == OP_MULTI_UPD && prm[3:0] == 4'h0))
    else $error("empty update issued");
  a_drv_drop: assert property (p_drop(op == OP_DRV_CLR && motion.servo_on[ax]))
    else $error("alarm clear issued with servo on");
  a_intr_drop: assert property (p_drop(op == OP_INTR && !motion.evt_pending))
    else $error("interrupt command issued without event");
  a_mode_drop: assert property (p_drop(op == OP_MODE && motion.moving[ax] &&
    work_modes[{ax, 1'b0} +: 2] != `HCES_MODE_GEAR)) else $error("mode change while moving");
  a_capt_drop: assert property (p_drop(op inside {OP_IDX_CAPT, OP_HOME_CAPT} &&
    motion.capt_done[ax])) else $error("capture arm issued while done");
  a_good_issue: assert property (go && op inside {[OP_TGT_POS:OP_LIMIT]} &&
    prm[31:24] == 8'h0 |-> ##3 s_issued) else $error("legal command not issued");
  a_mode_apply: assert property (go && op == OP_MODE && !motion.moving[ax] |->
    ##3 s_issued ##0 work_modes[{cmd_q[9:8], 1'b0} +: 2] == prm[1:0]) else $error("mode lost");
  a_issue_pulse: assert property (issue.valid |=> !issue.valid)
    else $error("issue longer than one cycle");
  a_err_rsvd: assert property (rd_q && adr_q == `HCES_ADDR_ERR |->
    (hrdata & ~32'h000000df) == 32'h0) else $error("unused error bits set");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule

bind hces_top hces_top_sva u_sva (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .motion(motion), .capt_taken(capt_taken), .issue(issue), .work_modes(work_modes),
  .irq(irq));

//--- testbench/hces_motion_model.sv
// Purpose: Axis side feeding state to the command checker
// Assumes: Bench levels are retimed onto core_clk
// Notes: A capture completes only on a trigger after arming
`timescale 1ns/1ps
module hces_motion_model (
  // Clock and reset
  input logic core_clk,
  input logic rst_b,
  // Bench controls
  input logic [3:0] set_moving,
  input logic [3:0] set_servo,
  input logic set_evt,
  input logic [3:0] trig,
  input logic [3:0] done_clr,
  // Checker side
  input hces_pkg::hces_issue_t issue,
  output hces_pkg::hces_motion_t motion,
  output logic [3:0] capt_taken,
  output logic [7:0] issued
);
  import hces_pkg::*;
  logic [3:0] armed_m;
  logic arm_hit;
  assign arm_hit = issue.valid && issue.cmd.op inside {OP_IDX_CAPT, OP_HOME_CAPT};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      motion <= 13'h0000;
    end else begin
      motion.moving <= set_moving;
      motion.servo_on <= set_servo;
      motion.evt_pending <= set_evt;
      motion.capt_done <= (motion.capt_done | (trig & armed_m)) & ~done_clr;
    end
  end
  // Arming follows issued commands only, so a dropped arm never captures
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_m <= 4'h0;
      capt_taken <= 4'h0;
      issued <= 8'h00;
    end else begin
      armed_m <= (armed_m & ~trig) | (arm_hit ? 4'h1 << issue.cmd.axis : 4'h0);
      capt_taken <= trig & armed_m;
      issued <= issued + {7'h0, issue.valid};
    end
  end
endmodule

//--- testbench/tb_hces_top.sv
// Purpose: Self-checking bench of the command checker
// Assumes: Zero-wait bus, hready looped from hreadyout
// Notes: Result word is {issues, ret code, error flags}
`timescale 1ns/1ps
`include "hces_params.svh"
module tb_hces_top;
  import hces_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq;
  logic [31:0] hrdata;
  hces_motion_t motion;
  hces_issue_t issue;
  logic [3:0] capt_taken;
  logic [7:0] work_modes, issued;
  logic [3:0] mv = 4'h0, sv = 4'h0, trig = 4'h0, dclr = 4'h0;
  logic evt = 1'b0;
  int errors = 0, comparisons = 0, cycles = 0;
  hces_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .motion(motion),
    .capt_taken(capt_taken), .issue(issue), .work_modes(work_modes), .irq(irq));
  hces_motion_model u_axes (.core_clk(core_clk), .rst_b(rst_b), .set_moving(mv),
    .set_servo(sv), .set_evt(evt), .trig(trig), .done_clr(dclr), .issue(issue),
    .motion(motion), .capt_taken(capt_taken), .issued(issued));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("BAD t=%0t timeout", $time);
      summarize;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("Counts: %0d compares, %0d mismatches", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Entered just after an edge; the address phase holds until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= `HCES_HSIZE_WORD;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Launch, poll busy, then read and clear the causes
  task automatic run(input logic [7:0] op, input logic [1:0] ax, input logic [31:0] p,
    output logic [31:0] v);
    logic [31:0] q, e;
    logic [7:0] n0;
    int n;
    n0 = issued;
    ahb(1'b1, `HCES_ADDR_PARAM, p, q);
    ahb(1'b1, `HCES_ADDR_CMD, {22'h0, ax, op}, q);
    q = 32'h2;
    for (n = 0; n < 20 && q[1] !== 1'b0; n++) ahb(1'b0, `HCES_ADDR_RET, 32'h0, q);
    ahb(1'b0, `HCES_ADDR_ERR, 32'h0, e);
    v = {issued - n0, 7'h0, q[0], e[15:0]};
  endtask
  task automatic t_reset;
    logic [31:0] q;
    ahb(1'b0, `HCES_ADDR_ERR, 32'h0, q);
    check(q, 32'h0);
    ahb(1'b1, 8'h3c, 32'hffffffff, q);
    ahb(1'b0, 8'h3c, 32'h0, q);
    check(q, 32'h0);
    $display("Test reset done");
  endtask
  task automatic t_param;
    logic [31:0] v, q;
    logic [7:0] ops [5] = '{OP_VEL, OP_ACC, OP_JERK, OP_GAIN, OP_LIMIT};
    run(OP_TGT_POS, 2'h0, 32'h00000100, v);
    check(v, 32'h01000000);
    run(OP_TGT_POS, 2'h0, 32'h40000000, v);
    check(v, 32'h00010001);
    run(OP_TGT_POS, 2'h1, 32'h3fffffff, v);
    check(v, 32'h01000000);
    run(OP_ACT_POS, 2'h1, 32'hc0000000, v);
    check(v, 32'h00010001);
    run(OP_VEL, 2'h0, 32'h01000000, v);
    check(v, 32'h00010001);
    run(OP_ACC, 2'h1, 32'h00ffffff, v);
    check(v, 32'h01000000);
    ahb(1'b1, `HCES_ADDR_SEL, 32'h0, q);
    ahb(1'b0, `HCES_ADDR_RDBK, 32'h0, q);
    check(q, 32'h00000100);
    foreach (ops[i]) begin
      run(ops[i], 2'h2, 32'hffffffff, v);
      check(v, 32'h00010002);
    end
    run(OP_ACC, 2'h3, 32'hfe000000, v);
    check(v, 32'h00010003);
    $display("Test parameters done");
  endtask
  task automatic t_gates;
    logic [31:0] v;
    run(OP_MULTI_UPD, 2'h0, 32'h0, v);
    check(v, 32'h00010004);
    run(OP_MULTI_UPD, 2'h0, 32'h00000010, v);
    check(v, 32'h00010004);
    run(OP_MULTI_UPD, 2'h0, 32'h8, v);
    check(v, 32'h01000000);
    sv <= 4'h2;
    run(OP_DRV_CLR, 2'h1, 32'h0, v);
    check(v, 32'h00010008);
    run(OP_DRV_CLR, 2'h0, 32'h0, v);
    check(v, 32'h01000000);
    $display("Test gates done");
  endtask
  task automatic t_intr;
    logic [31:0] v, q;
    ahb(1'b1, `HCES_ADDR_IRQ_MASK, 32'h1, q);
    ahb(1'b0, `HCES_ADDR_IRQ_STS, 32'h0, q);
    run(OP_INTR, 2'h0, 32'h0, v);
    check(v, 32'h00010010);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h1);
    ahb(1'b0, `HCES_ADDR_IRQ_STS, 32'h0, q);
    check(q, 32'h1);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    ahb(1'b1, `HCES_ADDR_IRQ_MASK, 32'h2, q);
    run(OP_INTR, 2'h0, 32'h0, v);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    evt <= 1'b1;
    run(OP_INTR, 2'h0, 32'h0, v);
    check(v, 32'h01000000);
    $display("Test interrupt done");
  endtask
  task automatic t_mode;
    logic [31:0] v;
    mv <= 4'h4;
    run(OP_MODE, 2'h2, 32'h1, v);
    check(v, 32'h00010040);
    check({24'h0, work_modes}, 32'h00000000);
    mv <= 4'h0;
    run(OP_MODE, 2'h2, 32'h3, v);
    check(v, 32'h01000000);
    check({24'h0, work_modes}, 32'h00000030);
    mv <= 4'h4;
    run(OP_MODE, 2'h2, 32'h1, v);
    check(v, 32'h01000000);
    check({24'h0, work_modes}, 32'h00000010);
    run(OP_MODE, 2'h2, 32'h2, v);
    check(v, 32'h00010040);
    $display("Test mode done");
  endtask
  task automatic t_capt;
    logic [31:0] v;
    run(OP_IDX_CAPT, 2'h3, 32'h0, v);
    check(v, 32'h01000000);
    run(OP_HOME_CAPT, 2'h3, 32'h0, v);
    check(v, 32'h00010080);
    trig <= 4'h8;
    @(posedge core_clk);
    trig <= 4'h0;
    run(OP_HOME_CAPT, 2'h3, 32'h0, v);
    check(v, 32'h00010080);
    dclr <= 4'h8;
    @(posedge core_clk);
    dclr <= 4'h0;
    run(OP_HOME_CAPT, 2'h3, 32'h0, v);
    check(v, 32'h01000000);
    run(OP_IDX_CAPT, 2'h3, 32'h0, v);
    check(v, 32'h00010080);
    $display("Test capture done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset;
    t_param;
    t_gates;
    t_intr;
    t_mode;
    t_capt;
    summarize;
  end
endmodule
